// ===== src/spm_cfg.svh
// Purpose: frame layout, pointer codes and store sizes of the pointer mover
// Assumes: one byte per sys_clk, nine rows of ninety columns per frame
// Notes: definitions only
// Operation
// - one mover per slice; both slices share the system frame pulse
// - outgoing bytes follow the frame position set by the system frame pulse
// - received K1, K2 and SS bits reach the outgoing stream
// - concatenations of three STS-1 multiples on STS-3 boundaries are handled
// - only valid payload bytes are written into the elastic store
// - increment and decrement need 8 of 10 bits matching, new data 3 of 4 flag bits
// - one differing in-range pointer is ignored
// - two consecutive differing normal pointers load the later value
// - three states; two consecutive normal pointers enter the regular state
// - two chained pointers enter chained state using the head offset
// - two alarm pointers enter alarm state; two normal or chained leave it
// - alarm fills payload and H1 to H3 with all ones until J1 returns
// - single bit pointer errors change neither data flow nor state
// - generator places bytes and builds pointers from the marked J1
// - generator sends new data indicator on leaving alarm
// - unexpected J1 position resets outgoing pointer and sends new data indicator
// - adjust requests latch once per frame at F1 or E2
// - latch byte changes only when received H bytes collide with it
// - every adjustment passes on at the next F1 or E2 latch with no rate limit
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_COLS 7'd90
`define SPM_ROWS 4'd9
`define SPM_TOH_COLS 7'd3
`define SPM_SPE_COLS 10'd87
`define SPM_PTR_ROW 4'd3
`define SPM_K_ROW 4'd4
`define SPM_F1_ROW 4'd2
`define SPM_E2_ROW 4'd8
`define SPM_COL_0 7'd0
`define SPM_COL_1 7'd1
`define SPM_COL_2 7'd2
`define SPM_MAX_OFS 10'd782
`define SPM_OFS_RST 10'd0
`define SPM_CHAINED_PAYLOAD_STATE_VAL 10'h3ff
`define SPM_NDF_REGULAR_POINTER_STATE 4'h6
`define SPM_NDF_SET 4'h9
`define SPM_ALL_ONES 16'hffff
`define SPM_FILL 8'hff
`define SPM_I_MASK 10'h2aa
`define SPM_D_MASK 10'h155
`define SPM_VOTE_MIN 4'd8
`define SPM_NDF_VOTE 4'd3
`define SPM_ES_DEPTH 16
`define SPM_ES_AW 4
`define SPM_PRIME_LVL 4'd8
`endif

// ===== src/spm_pkg.sv
// Purpose: types shared by the pointer mover and its elastic store
// Assumes: nothing
// Notes: constants live in spm_cfg.svh
package spm_pkg;
  typedef enum logic [1:0] {
    REGULAR_POINTER_STATE,
    CHAINED_PAYLOAD_STATE,
    ALARM_FILL_STATE
  } spm_state_t;
  typedef enum logic [2:0] {
    KIND_NORMAL, KIND_NDF, KIND_CHAINED_PAYLOAD_STATE, KIND_ALARM, KIND_INC, KIND_DEC, KIND_BAD
  } spm_kind_t;
  typedef struct packed {
    logic       j1;
    logic [7:0] data;
  } spm_entry_t;
endpackage

// ===== src/spm_store_if.sv
// Purpose: write and read side of the elastic store
// Assumes: one clock
// Notes: user is the mover, store is the buffer
`timescale 1ns/1ns
`default_nettype none
interface spm_store_if;
  import spm_pkg::*;
  logic       wrEn;
  spm_entry_t wrEntry;
  logic       rdEn;
  spm_entry_t rdEntry;
  logic       full;
  logic       empty;
  modport user  (output wrEn, wrEntry, rdEn, input rdEntry, full, empty);
  modport store (input wrEn, wrEntry, rdEn, output rdEntry, full, empty);
endinterface
`default_nettype wire

// ===== src/spm_elastic_store.sv
// Purpose: elastic store between interpreter and generator
// Assumes: writes and reads on sys_clk
// Notes: a write into a full store is dropped, a read from empty leaves the read position unchanged
`timescale 1ns/1ns
`default_nettype none
`include "spm_cfg.svh"
module spm_elastic_store
  import spm_pkg::*;
(
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   srst,
  // store side
  spm_store_if.store sif
);
  spm_entry_t             mem_q [`SPM_ES_DEPTH];
  logic [`SPM_ES_AW-1:0]  wrIdx_q;
  logic [`SPM_ES_AW-1:0]  rdIdx_q;
  logic [`SPM_ES_AW:0]    count_q;
  logic                   doWr;
  logic                   doRd;

  // separate positions let frames drift against the system frame
  assign doWr        = sif.wrEn && !sif.full;
  assign doRd        = sif.rdEn && !sif.empty;
  assign sif.full    = count_q == (`SPM_ES_AW+1)'(`SPM_ES_DEPTH);
  assign sif.empty   = count_q == '0;
  assign sif.rdEntry = mem_q[rdIdx_q];

  // storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem_q[wrIdx_q] <= sif.wrEntry;
    end
  end

  // positions and fill level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= '0;
    end else begin
      wrIdx_q <= wrIdx_q + (`SPM_ES_AW)'(doWr);
      rdIdx_q <= rdIdx_q + (`SPM_ES_AW)'(doRd);
      count_q <= count_q + (`SPM_ES_AW+1)'(doWr) - (`SPM_ES_AW+1)'(doRd);
    end
  end
endmodule
`default_nettype wire

// ===== src/spm_pointer_mover.sv
// Purpose: receive pointer interpreter and generator for one slice
// Assumes: one byte per clock in each direction, frame pulses on the first byte
// Notes: instantiate once per slice, both fed by the same system frame pulse
`timescale 1ns/1ns
`default_nettype none
`include "spm_cfg.svh"
module spm_pointer_mover
  import spm_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // received stream, same clock
  input  wire logic [7:0] rxData,
  input  wire logic       rxFramePulse,
  input  wire logic [9:0] chainHeadOffset,
  // system framing, shared by all slices
  input  wire logic       systemFramePulse,
  // re-timed stream
  output logic [7:0]      txData_q,
  output logic            txFramePulse_q,
  output logic            txSpe_q,
  output logic            txJ1_q,
  // status
  output logic            alarmFill_q,
  output logic            chainedPayload_q,
  output logic            newDataIndicator_q
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] speIndex(input logic [3:0] r, input logic [6:0] c);
    logic [3:0] rel;
    rel = (r >= `SPM_PTR_ROW) ? r - `SPM_PTR_ROW : r + (`SPM_ROWS - `SPM_PTR_ROW);
    speIndex = 10'(rel * `SPM_SPE_COLS) + {3'd0, c - `SPM_TOH_COLS};
  endfunction

  function automatic logic [3:0] countOnes(input logic [9:0] v);
    countOnes = '0;
    for (int i = 0; i < 10; i++) begin
      countOnes = countOnes + 4'(v[i]);
    end
  endfunction

  // ----------------------------------------------------------------
  // frame position: index 0 received, index 1 system
  // ----------------------------------------------------------------
  logic [1:0]  pulse;
  logic [6:0]  col_q [2];
  logic [6:0]  colNow [2];
  logic [3:0]  row_q [2];
  logic [3:0]  rowNow [2];
  logic [9:0]  speIdx [2];
  logic [1:0]  isSpe;
  logic [1:0]  isH1;
  logic [1:0]  isH2;
  logic [1:0]  isH3;

  assign pulse = {systemFramePulse, rxFramePulse};

  // tx side counts from the system pulse, so output framing follows it
  for (genvar g = 0; g < 2; g++) begin : g_pos
    assign colNow[g] = pulse[g] ? 7'd0 : col_q[g];
    assign rowNow[g] = pulse[g] ? 4'd0 : row_q[g];
    assign isSpe[g]  = colNow[g] >= `SPM_TOH_COLS;
    assign speIdx[g] = speIndex(rowNow[g], colNow[g]);
    assign isH1[g]   = rowNow[g] == `SPM_PTR_ROW && colNow[g] == `SPM_COL_0;
    assign isH2[g]   = rowNow[g] == `SPM_PTR_ROW && colNow[g] == `SPM_COL_1;
    assign isH3[g]   = rowNow[g] == `SPM_PTR_ROW && colNow[g] == `SPM_COL_2;
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        col_q[g] <= '0;
        row_q[g] <= '0;
      end else if (colNow[g] == `SPM_COLS - 7'd1) begin
        col_q[g] <= '0;
        row_q[g] <= (rowNow[g] == `SPM_ROWS - 4'd1) ? 4'd0 : rowNow[g] + 4'd1;
      end else begin
        col_q[g] <= colNow[g] + 7'd1;
        row_q[g] <= rowNow[g];
      end
    end
  end

  logic rxIsK1;
  logic rxIsK2;
  logic rxIsH;
  logic txIsK1;
  logic txIsK2;
  logic txIsF1;
  logic txIsE2;
  assign rxIsK1 = rowNow[0] == `SPM_K_ROW && colNow[0] == `SPM_COL_1;
  assign rxIsK2 = rowNow[0] == `SPM_K_ROW && colNow[0] == `SPM_COL_2;
  assign rxIsH  = isH1[0] || isH2[0] || isH3[0];
  assign txIsK1 = rowNow[1] == `SPM_K_ROW && colNow[1] == `SPM_COL_1;
  assign txIsK2 = rowNow[1] == `SPM_K_ROW && colNow[1] == `SPM_COL_2;
  assign txIsF1 = rowNow[1] == `SPM_F1_ROW && colNow[1] == `SPM_COL_2;
  assign txIsE2 = rowNow[1] == `SPM_E2_ROW && colNow[1] == `SPM_COL_2;

  // ----------------------------------------------------------------
  // interpreter: pointer decode
  // ----------------------------------------------------------------
  logic [7:0]  h1Byte_q;
  logic [15:0] ptrWord;
  logic [9:0]  ptrVal;
  logic        ndfNorm;
  logic        ndfSet;
  logic        incVote;
  logic        decVote;
  spm_kind_t   kind;
  spm_kind_t   prevKind_q;
  spm_state_t  intState_q;
  logic [9:0]  offset_q;
  logic [9:0]  activeOfs;
  logic        diffPending_q;
  logic        incFrame_q;
  logic        decFrame_q;

  assign ptrWord = {h1Byte_q, rxData};
  assign ptrVal  = ptrWord[9:0];
  // majority vote on flag nibble and on the inverted I or D bits
  assign ndfNorm = countOnes({6'd0, ~(ptrWord[15:12] ^ `SPM_NDF_REGULAR_POINTER_STATE)}) >= `SPM_NDF_VOTE;
  assign ndfSet  = countOnes({6'd0, ~(ptrWord[15:12] ^ `SPM_NDF_SET)}) >= `SPM_NDF_VOTE;
  assign incVote = countOnes(~(ptrVal ^ offset_q ^ `SPM_I_MASK)) >= `SPM_VOTE_MIN;
  assign decVote = countOnes(~(ptrVal ^ offset_q ^ `SPM_D_MASK)) >= `SPM_VOTE_MIN;

  // classify; an exact match is checked before the I and D votes so one flipped bit cannot vote
  always_comb begin
    if (ptrWord == `SPM_ALL_ONES) begin
      kind = KIND_ALARM;
    end else if (ndfSet && ptrVal == `SPM_CHAINED_PAYLOAD_STATE_VAL) begin
      kind = KIND_CHAINED_PAYLOAD_STATE;
    end else if (ndfSet && ptrVal <= `SPM_MAX_OFS) begin
      kind = KIND_NDF;
    end else if (ndfNorm && ptrVal == offset_q) begin
      kind = KIND_NORMAL;
    end else if (ndfNorm && incVote && intState_q == REGULAR_POINTER_STATE) begin
      kind = KIND_INC;
    end else if (ndfNorm && decVote && intState_q == REGULAR_POINTER_STATE) begin
      kind = KIND_DEC;
    end else if (ndfNorm && ptrVal <= `SPM_MAX_OFS) begin
      kind = KIND_NORMAL;
    end else begin
      kind = KIND_BAD;
    end
  end

  logic prevNormal;
  logic curNormal;
  assign curNormal  = kind inside {KIND_NORMAL, KIND_NDF, KIND_INC, KIND_DEC};
  assign prevNormal = prevKind_q inside {KIND_NORMAL, KIND_NDF, KIND_INC, KIND_DEC};

  // state follows two consecutive pointers of one class
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intState_q <= REGULAR_POINTER_STATE;
      prevKind_q <= KIND_BAD;
    end else if (isH2[0]) begin
      prevKind_q <= kind;
      if (kind == KIND_ALARM && prevKind_q == KIND_ALARM) begin
        intState_q <= ALARM_FILL_STATE;
      end else if (kind == KIND_CHAINED_PAYLOAD_STATE && prevKind_q == KIND_CHAINED_PAYLOAD_STATE) begin
        intState_q <= CHAINED_PAYLOAD_STATE;
      end else if (curNormal && prevNormal) begin
        intState_q <= REGULAR_POINTER_STATE;
      end
    end
  end

  // chained members locate payload from the chain head
  always_comb begin
    case (intState_q)
      REGULAR_POINTER_STATE: activeOfs = offset_q;
      CHAINED_PAYLOAD_STATE: activeOfs = chainHeadOffset;
      ALARM_FILL_STATE:      activeOfs = offset_q;
      default:               activeOfs = offset_q;
    endcase
  end

  // offset tracking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      offset_q      <= `SPM_OFS_RST;
      diffPending_q <= 1'b0;
      incFrame_q    <= 1'b0;
      decFrame_q    <= 1'b0;
    end else begin
      if (isH1[0]) begin
        incFrame_q <= 1'b0;
        decFrame_q <= 1'b0;
      end
      if (isH2[0]) begin
        diffPending_q <= 1'b0;
        case (kind)
          KIND_NDF: offset_q <= ptrVal;
          KIND_INC: begin
            offset_q   <= (offset_q == `SPM_MAX_OFS) ? 10'd0 : offset_q + 10'd1;
            incFrame_q <= 1'b1;
          end
          KIND_DEC: begin
            offset_q   <= (offset_q == 10'd0) ? `SPM_MAX_OFS : offset_q - 10'd1;
            decFrame_q <= 1'b1;
          end
          KIND_NORMAL: begin
            if (ptrVal != offset_q) begin
              if (diffPending_q) begin
                offset_q <= ptrVal;
              end else begin
                diffPending_q <= 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // pointer and overhead captures
  logic [1:0] ssBits_q;
  logic [7:0] k1Byte_q;
  logic [7:0] k2Byte_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      h1Byte_q <= '0;
      ssBits_q <= '0;
      k1Byte_q <= '0;
      k2Byte_q <= '0;
    end else begin
      if (isH1[0]) h1Byte_q <= rxData;
      if (isH2[0]) ssBits_q <= ptrWord[11:10];
      if (rxIsK1) k1Byte_q <= rxData;
      if (rxIsK2) k2Byte_q <= rxData;
    end
  end

  // ----------------------------------------------------------------
  // elastic store
  // ----------------------------------------------------------------
  spm_store_if sif ();
  spm_elastic_store u_store (
    .sys_clk (sys_clk),
    .srst    (srst),
    .sif     (sif)
  );

  // only payload bytes; stuff skipped, H3 taken on decrement; none in alarm
  assign sif.wrEn = intState_q != ALARM_FILL_STATE &&
                    ((isSpe[0] && !(incFrame_q && speIdx[0] == 10'd0)) || (isH3[0] && decFrame_q));
  assign sif.wrEntry = '{j1: isSpe[0] && speIdx[0] == activeOfs, data: rxData};

  // ----------------------------------------------------------------
  // generator
  // ----------------------------------------------------------------
  logic       incReq_q;
  logic       decReq_q;
  logic       incLatched_q;
  logic       decLatched_q;
  logic       latchOnE2_q;
  logic       latchNow;
  logic       genAlarm_q;
  logic       ndfPending_q;
  logic [9:0] txOfs_q;
  logic       primed_q;
  logic [3:0] primeCnt_q;
  logic       rdJ1;
  logic [9:0] ptrOut;

  assign latchNow = latchOnE2_q ? txIsE2 : txIsF1;
  // skip the stuff byte on increment, read into H3 on decrement
  assign sif.rdEn = !sif.empty && primed_q &&
                    ((isSpe[1] && !(incLatched_q && speIdx[1] == 10'd0)) || (isH3[1] && decLatched_q));
  assign rdJ1 = sif.rdEn && sif.rdEntry.j1;

  // reads wait for a margin in the store, so a skipped stuff byte cannot starve a read slot
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      primed_q   <= 1'b0;
      primeCnt_q <= '0;
    end else if (primed_q) begin
      if (sif.empty) begin
        primed_q   <= 1'b0;
        primeCnt_q <= '0;
      end
    end else if (sif.wrEn && !sif.full) begin
      primeCnt_q <= primeCnt_q + 4'd1;
      primed_q   <= primeCnt_q == `SPM_PRIME_LVL - 4'd1;
    end
  end

  // every detected adjust is queued with no spacing check; set wins over latch clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      incReq_q     <= 1'b0;
      decReq_q     <= 1'b0;
      incLatched_q <= 1'b0;
      decLatched_q <= 1'b0;
    end else begin
      if (latchNow) begin
        incLatched_q <= incReq_q;
        decLatched_q <= decReq_q;
        incReq_q     <= 1'b0;
        decReq_q     <= 1'b0;
      end
      if (isH2[0] && kind == KIND_INC) incReq_q <= 1'b1;
      if (isH2[0] && kind == KIND_DEC) decReq_q <= 1'b1;
    end
  end

  // latch byte moves only on collision with received H bytes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latchOnE2_q <= 1'b0;
    end else if (rxIsH && txIsF1 && !latchOnE2_q) begin
      latchOnE2_q <= 1'b1;
    end else if (rxIsH && txIsE2 && latchOnE2_q) begin
      latchOnE2_q <= 1'b0;
    end
  end

  // outgoing offset, alarm fill and new data indicator
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txOfs_q      <= `SPM_OFS_RST;
      genAlarm_q   <= 1'b0;
      ndfPending_q <= 1'b0;
    end else begin
      if (isH2[1]) ndfPending_q <= 1'b0;
      if (isH2[1] && incLatched_q) begin
        txOfs_q <= (txOfs_q == `SPM_MAX_OFS) ? 10'd0 : txOfs_q + 10'd1;
      end else if (isH2[1] && decLatched_q) begin
        txOfs_q <= (txOfs_q == 10'd0) ? `SPM_MAX_OFS : txOfs_q - 10'd1;
      end
      if (rdJ1 && speIdx[1] != txOfs_q) begin
        txOfs_q      <= speIdx[1];
        ndfPending_q <= 1'b1;
      end
      if (intState_q == ALARM_FILL_STATE) begin
        genAlarm_q <= 1'b1;
      end else if (genAlarm_q && rdJ1) begin
        genAlarm_q   <= 1'b0;
        ndfPending_q <= 1'b1;
      end
    end
  end

  // I or D bits invert on the frame that carries the adjust
  assign ptrOut = (intState_q == CHAINED_PAYLOAD_STATE) ? `SPM_CHAINED_PAYLOAD_STATE_VAL :
                  txOfs_q ^ (incLatched_q ? `SPM_I_MASK : decLatched_q ? `SPM_D_MASK : 10'd0);

  // output byte mux, registered so every port leaves a flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txData_q           <= '0;
      txFramePulse_q     <= 1'b0;
      txSpe_q            <= 1'b0;
      txJ1_q             <= 1'b0;
      newDataIndicator_q <= 1'b0;
    end else begin
      txFramePulse_q     <= systemFramePulse;
      txSpe_q            <= isSpe[1];
      txJ1_q             <= rdJ1 && !genAlarm_q;
      newDataIndicator_q <= isH1[1] && ndfPending_q && !genAlarm_q;
      if (genAlarm_q && (isSpe[1] || isH1[1] || isH2[1] || isH3[1])) begin
        txData_q <= `SPM_FILL;
      end else if (isH1[1]) begin
        txData_q <= {(ndfPending_q || intState_q == CHAINED_PAYLOAD_STATE) ? `SPM_NDF_SET : `SPM_NDF_REGULAR_POINTER_STATE,
                     ssBits_q, ptrOut[9:8]};
      end else if (isH2[1]) begin
        txData_q <= ptrOut[7:0];
      end else if (txIsK1) begin
        txData_q <= k1Byte_q;
      end else if (txIsK2) begin
        txData_q <= k2Byte_q;
      end else if (sif.rdEn) begin
        txData_q <= sif.rdEntry.data;
      end else begin
        txData_q <= '0;
      end
    end
  end

  // status flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarmFill_q      <= 1'b0;
      chainedPayload_q <= 1'b0;
    end else begin
      alarmFill_q      <= genAlarm_q;
      chainedPayload_q <= intState_q == CHAINED_PAYLOAD_STATE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence sHTimes;
    isH1[1] ##1 isH2[1] ##1 isH3[1];
  endsequence

  a_alarm_fill_data: assert property (genAlarm_q && isSpe[1] |=> txData_q == `SPM_FILL)
    else $error("payload not filled during alarm");
  a_alarm_pair_enter: assert property (isH2[0] && kind == KIND_ALARM && prevKind_q == KIND_ALARM
    |=> intState_q == ALARM_FILL_STATE)
    else $error("two alarm pointers did not enter alarm");
  a_chain_pair_enter: assert property (isH2[0] && kind == KIND_CHAINED_PAYLOAD_STATE && prevKind_q == KIND_CHAINED_PAYLOAD_STATE
    |=> intState_q == CHAINED_PAYLOAD_STATE)
    else $error("two chained pointers did not enter chained state");
  a_normal_pair_enter: assert property (isH2[0] && curNormal && prevNormal
    |=> intState_q == REGULAR_POINTER_STATE)
    else $error("two normal pointers did not enter regular state");
  a_single_diff_ignored: assert property (isH2[0] && kind == KIND_NORMAL && ptrVal != offset_q
    && !diffPending_q |=> $stable(offset_q) && ($stable(intState_q) || $past(prevNormal)))
    else $error("single differing pointer was not ignored");
  a_second_diff_loads: assert property (isH2[0] && kind == KIND_NORMAL && ptrVal != offset_q
    && diffPending_q |=> offset_q == $past(ptrVal))
    else $error("second differing pointer not loaded");
  a_no_alarm_write: assert property (intState_q == ALARM_FILL_STATE |-> !sif.wrEn)
    else $error("store written in alarm state");
  a_j1_resync_ndf: assert property (rdJ1 && speIdx[1] != txOfs_q
    |=> ndfPending_q && txOfs_q == $past(speIdx[1]))
    else $error("unexpected J1 did not reset outgoing pointer");
  a_latch_hold_h: assert property (sHTimes |-> $stable(incLatched_q) && $stable(decLatched_q))
    else $error("adjust latch moved during H bytes");
  a_alarm_exit_ndf: assert property ($fell(genAlarm_q) |-> ndfPending_q)
    else $error("no new data indicator after alarm");
  a_k1_forward: assert property (txIsK1 |=> txData_q == $past(k1Byte_q))
    else $error("K1 not forwarded");
endmodule
`default_nettype wire

// ===== bench/spm_rx_source.sv
// Purpose: upstream framer model, one STS-1 frame of 810 bytes after another
// Assumes: ptrWord is held steady while H1 and H2 go out
// Notes: payload follows the frame position so a stuck byte never looks right
`timescale 1ns/1ns
`default_nettype none
module spm_rx_source (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // pointer to send as {H1,H2}
  input  wire logic [15:0] ptrWord,
  // received stream
  output logic [7:0]       rxData,
  output logic             rxFramePulse
);
  logic [9:0] pos_q;
  // ----------------------------------------------------------------
  // frame position and byte selection
  // ----------------------------------------------------------------
  // chain head sits in STS-1 number one, a start that is always legal
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pos_q <= 10'h000;
      rxData <= 8'h00;
      rxFramePulse <= 1'b0;
    end else begin
      pos_q <= (pos_q == 10'd809) ? 10'h000 : pos_q + 10'h001;
      rxFramePulse <= (pos_q == 10'h000);
      case (pos_q)
        10'd270: rxData <= ptrWord[15:8];
        10'd271: rxData <= ptrWord[7:0];
        10'd361: rxData <= 8'h3c; // K1
        10'd362: rxData <= 8'hc3; // K2
        default: rxData <= pos_q[7:0] ^ 8'h5a;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== bench/spm_pointer_mover_bench.sv
// Purpose: self-checking bench of the pointer mover
// Assumes: system frame phase 400 clocks away from the received frame
// Notes: newDataIndicator_q pulses are counted, not timed
`timescale 1ns/1ns
`default_nettype none
module spm_pointer_mover_bench;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        systemFramePulse = 1'b0;
  logic [15:0] ptrWord = 16'h680a;
  logic [9:0]  sysPos = 10'h000;
  logic [9:0]  chainHead = 10'd10;
  logic [7:0]  rxData, txData_q;
  logic        rxFramePulse, txFramePulse_q, txSpe_q, txJ1_q;
  logic        alarmFill_q, chainedPayload_q, newDataIndicator_q;
  int          errors = 0, num_checks = 0, ndfCount = 0, j1Count = 0, cycles = 0, n0;
  spm_rx_source src (.sys_clk(sys_clk), .srst(srst), .ptrWord(ptrWord), .rxData(rxData),
    .rxFramePulse(rxFramePulse));
  spm_pointer_mover dut (.sys_clk(sys_clk), .srst(srst), .rxData(rxData), .rxFramePulse(rxFramePulse),
    .chainHeadOffset(chainHead), .systemFramePulse(systemFramePulse), .txData_q(txData_q),
    .txFramePulse_q(txFramePulse_q), .txSpe_q(txSpe_q), .txJ1_q(txJ1_q), .alarmFill_q(alarmFill_q),
    .chainedPayload_q(chainedPayload_q), .newDataIndicator_q(newDataIndicator_q));
  // ----------------------------------------------------------------
  // clock, system framing, monitors
  // ----------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;
  // system frame pulse every 810 clocks, out of phase with the received frames
  always @(posedge sys_clk) begin
    sysPos <= (srst || sysPos == 10'd809) ? 10'h000 : sysPos + 10'h001;
    systemFramePulse <= !srst && sysPos == 10'd400;
    if (newDataIndicator_q === 1'b1) ndfCount <= ndfCount + 1;
    if (txJ1_q === 1'b1) j1Count <= j1Count + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] nrm(input logic [9:0] v);
    return {4'h6, 2'b10, v};
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // n consecutive frames with one pointer, returning once the last one is decided
  task automatic frames(input logic [15:0] w, input int n);
    @(posedge sys_clk iff rxFramePulse === 1'b1);
    ptrWord <= w;
    repeat (n - 1) @(posedge sys_clk iff rxFramePulse === 1'b1);
    repeat (300) @(posedge sys_clk);
  endtask
  task automatic at_tx(input int p);
    @(posedge sys_clk iff txFramePulse_q === 1'b1);
    repeat (p) @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_normal;
    frames(nrm(10'd10), 3);
    check("state", 16'h0000, {alarmFill_q, chainedPayload_q});
    at_tx(270);
    check("H1 flag and SS", 16'h001a, {10'h000, txData_q[7:2]});
    repeat (91) @(posedge sys_clk);
    check("K1", 16'h003c, {8'h00, txData_q});
    @(posedge sys_clk);
    check("K2", 16'h00c3, {8'h00, txData_q});
    @(posedge sys_clk);
    check("payload flag", 16'h0001, {15'h0, txSpe_q});
    n0 = j1Count;
    repeat (810) @(posedge sys_clk);
    check("J1 per frame", 16'h0001, 16'(j1Count - n0));
    $display("normal test done");
  endtask
  task automatic t_move;
    n0 = ndfCount;
    frames(nrm(10'd40), 1);
    frames(nrm(10'd10), 3);
    check("single pointer ignored", 16'h0000, {15'h0, ndfCount != n0});
    frames(nrm(10'd50), 1);
    frames(nrm(10'd60), 3);
    check("two pointers move", 16'h0001, {15'h0, ndfCount > n0});
    $display("move test done");
  endtask
  task automatic t_adjust;
    n0 = ndfCount;
    frames(nrm(10'h096), 1);
    frames(nrm(10'h168), 1);
    frames(nrm(10'd60), 3);
    check("adjust without flag", 16'h0000, {15'h0, ndfCount != n0});
    $display("adjust test done");
  endtask
  task automatic t_alarm;
    frames(16'hffff, 1);
    check("one alarm ignored", 16'h0000, {15'h0, alarmFill_q});
    frames(16'hffff, 2);
    check("alarm entered", 16'h0001, {15'h0, alarmFill_q});
    at_tx(270);
    check("H1 fill", 16'h00ff, {8'h00, txData_q});
    repeat (30) @(posedge sys_clk);
    check("payload fill", 16'h00ff, {8'h00, txData_q});
    n0 = ndfCount;
    frames(nrm(10'd60), 4);
    check("alarm left", 16'h0000, {15'h0, alarmFill_q});
    repeat (1700) @(posedge sys_clk);
    check("flag after alarm", 16'h0001, {15'h0, ndfCount > n0});
    $display("alarm test done");
  endtask
  task automatic t_chain;
    frames(16'h9bff, 1);
    check("one chained ignored", 16'h0000, {15'h0, chainedPayload_q});
    frames(16'h9bff, 1);
    check("chained entered", 16'h0001, {15'h0, chainedPayload_q});
    at_tx(270);
    check("chained H1 flag", 16'h0009, {12'h000, txData_q[7:4]});
    @(posedge sys_clk);
    check("chained H2", 16'h00ff, {8'h00, txData_q});
    frames(nrm(10'd60), 3);
    check("chained left", 16'h0000, {15'h0, chainedPayload_q});
    $display("chain test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check("reset outputs", 16'h0000, {txData_q, txFramePulse_q, txSpe_q, txJ1_q, alarmFill_q,
      chainedPayload_q, newDataIndicator_q, 2'b00});
    t_normal();
    t_move();
    t_adjust();
    t_alarm();
    t_chain();
    give_verdict();
  end
endmodule
`default_nettype wire
